// File: shared/cpr_consts.vh
/*
 * constants for the configuration power and pin function register bank.
 * assumes inclusion by bare name from the design files; definitions only.
 */
// Notes on behaviour
// RULE1: registers reachable only in config state, index match
// RULE2: power-up defaults 9CH, 88H, 70H
// RULE3: reserved bits read fixed values, ignore writes
// RULE4: parallel bit 2 low means low power
// RULE5: parallel bit 3 low enables extended modes
// RULE6: lock low blocks all config register access
// RULE7: cleared lock returns only through reset
// RULE8: power-down leaves address decoding untouched
// RULE9: software disables decoding with base below 100h
// RULE10: powered-down device still joins range checking
// RULE11: serial bit 3 low powers down primary
// RULE12: serial bit 7 low powers down secondary, infrared
// RULE13: pin bit 1 selects enhanced floppy two
// RULE14: pin bit 4 high forces density output high
// RULE15: pin bits 6,5 select floppy interface mode
// RULE16: pin bit 0 picks power-good or game select
// RULE17: pin bits 7,2 pick second drive, qualifier, irq
// RULE18: extended setup bits 1:0 select parallel mode
`ifndef CPR_CONSTS_VH
`define CPR_CONSTS_VH

// -----------------------------------------------------------------
// config indexes and apb byte addresses
// -----------------------------------------------------------------
`define CPR_IDX_PAR        8'h01
`define CPR_IDX_SER        8'h02
`define CPR_IDX_PIN        8'h03
`define CPR_IDX_LAST       8'h2F
`define CPR_ADDR_STATE     8'h00
`define CPR_ADDR_INDEX     8'h04
`define CPR_ADDR_DATA      8'h08
`define CPR_ADDR_EXT       8'h0C
`define CPR_ADDR_STATUS    8'h10

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define CPR_RST_PAR        8'h9C
`define CPR_RST_SER        8'h88
`define CPR_RST_PIN        8'h70
`define CPR_RST_EXT        2'h0

// -----------------------------------------------------------------
// writable masks and fixed read values
// -----------------------------------------------------------------
`define CPR_WMASK_PAR      8'h8C
`define CPR_FIXED_PAR      8'h10
`define CPR_WMASK_SER      8'h88
`define CPR_WMASK_PIN      8'hF7

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CPR_PAR_PWR        2
`define CPR_PAR_PRN        3
`define CPR_PAR_LOCK       7
`define CPR_SER_PRI        3
`define CPR_SER_SEC        7
`define CPR_PIN_GAME       0
`define CPR_PIN_FLOP2      1
`define CPR_PIN_IRQ        2
`define CPR_PIN_DEN        4
`define CPR_PIN_ENC        5
`define CPR_PIN_ID         6
`define CPR_PIN_QUAL       7

// -----------------------------------------------------------------
// floppy interface and parallel modes, shared pin roles
// -----------------------------------------------------------------
`define CPR_FLOP_M30       2'h0
`define CPR_FLOP_PS2       2'h1
`define CPR_FLOP_RSVD      2'h2
`define CPR_FLOP_AT        2'h3
`define CPR_PMODE_PRN      3'h4
`define CPR_PIN92_SECOND_DRIVE_INPUT     2'h0
`define CPR_PIN92_QUAL     2'h1
`define CPR_PIN92_IRQ      2'h2

`endif

// File: core/cpr_cfg_reg.v
/*
 * one 8-bit configuration register with write mask and fixed bits.
 * assumes a write strobe already qualified by state, index and lock.
 */
`include "cpr_consts.vh"
`timescale 1ns/1ps

module cpr_cfg_reg #(
  parameter [7:0] RST   = 8'h00,
  parameter [7:0] WMASK = 8'hFF,
  parameter [7:0] FIXED = 8'h00,
  parameter [7:0] STICK = 8'h00
) (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // write side
  input  wire       wr,
  input  wire [7:0] wdata,
  // register value as read
  output wire [7:0] value
);

  reg  [7:0] store;
  wire [7:0] next_store;

  // masked update; sticky bits may only fall
  assign next_store = ((store & ~WMASK) | (wdata & WMASK)) & ~(STICK & ~store); // [RULE7]

  // store with power-up default
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store <= RST; // [RULE2]
    end else if (wr) begin
      store <= next_store;
    end
  end

  // reserved bits read their fixed level
  assign value = (store & WMASK) | FIXED; // [RULE3]

endmodule

// File: core/cpr_regs.v
/*
 * apb slave for the parallel, serial power and pin function config regs.
 * assumes a single 200 MHz clock and apb master; peripherals outside.
 */
`include "cpr_consts.vh"
`timescale 1ns/1ps

module cpr_regs (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // power and parallel mode controls
  output reg         par_powered,
  output reg         par_mode_printer,
  output reg  [2:0]  par_mode,
  output reg         uart1_powered,
  output reg         uart2_powered,
  output reg         fast_infrared_block_powered,
  // floppy controls
  output reg         enhanced_floppy_two,
  output reg  [1:0]  floppy_if_mode,
  input  wire        drive_density_prog,
  output reg         drive_density_out,
  // shared pins and lock status
  output reg         pin_game_port_select,
  input  wire        game_port_hit,
  output reg  [1:0]  pin92_role,
  output reg         pin92_out,
  input  wire        irq_b_req,
  output reg         cfg_locked
);

  // -----------------------------------------------------------------
  // apb phases and configuration access gating
  // -----------------------------------------------------------------
  reg        cfg_state;
  reg  [7:0] config_select_index;
  reg  [1:0] ext_setup;
  wire       acc     = psel & penable & pready;
  wire       wr_acc  = acc & pwrite;
  wire       unlocked;
  wire [7:0] par_v;
  wire [7:0] ser_v;
  wire [7:0] pin_v;
  // index legal for the config data port while unlocked
  wire       idx_open = cfg_state & unlocked
                        & (config_select_index <= `CPR_IDX_LAST); // [RULE1] [RULE6]
  wire       data_wr  = wr_acc & (paddr == `CPR_ADDR_DATA) & idx_open;
  wire       wr_par   = data_wr & (config_select_index == `CPR_IDX_PAR); // [RULE1]
  wire       wr_ser   = data_wr & (config_select_index == `CPR_IDX_SER); // [RULE1]
  wire       wr_pin   = data_wr & (config_select_index == `CPR_IDX_PIN); // [RULE1]

  assign unlocked = par_v[`CPR_PAR_LOCK]; // [RULE6]

  // -----------------------------------------------------------------
  // the three configuration registers
  // -----------------------------------------------------------------
  cpr_cfg_reg #(
    .RST   (`CPR_RST_PAR),
    .WMASK (`CPR_WMASK_PAR),
    .FIXED (`CPR_FIXED_PAR),
    .STICK (8'h80)
  ) u_par (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_par),
    .wdata   (pwdata[7:0]),
    .value   (par_v)
  );

  cpr_cfg_reg #(
    .RST   (`CPR_RST_SER),
    .WMASK (`CPR_WMASK_SER),
    .FIXED (8'h00),
    .STICK (8'h00)
  ) u_ser (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_ser),
    .wdata   (pwdata[7:0]),
    .value   (ser_v)
  );

  cpr_cfg_reg #(
    .RST   (`CPR_RST_PIN),
    .WMASK (`CPR_WMASK_PIN),
    .FIXED (8'h00),
    .STICK (8'h00)
  ) u_pin (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_pin),
    .wdata   (pwdata[7:0]),
    .value   (pin_v)
  );

  // -----------------------------------------------------------------
  // config state, index and extended setup mode bits
  // -----------------------------------------------------------------
  // state and index writable always; ext setup follows the lock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_state           <= 1'b0;
      config_select_index <= 8'h00;
      ext_setup           <= `CPR_RST_EXT;
    end else if (wr_acc) begin
      if (paddr == `CPR_ADDR_STATE) begin
        cfg_state <= pwdata[0];
      end else if (paddr == `CPR_ADDR_INDEX) begin
        config_select_index <= pwdata[7:0];
      end else if (paddr == `CPR_ADDR_EXT) begin
        if (cfg_state & unlocked) begin // [RULE6]
          ext_setup <= pwdata[1:0];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // apb answer: one wait state, then ready
  // -----------------------------------------------------------------
  reg  [31:0] next_prdata;
  reg         next_err;

  // read mux and error decode
  always @* begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (paddr == `CPR_ADDR_STATE) begin
      next_prdata = {31'h0000_0000, cfg_state};
    end else if (paddr == `CPR_ADDR_INDEX) begin
      next_prdata = {24'h00_0000, config_select_index};
    end else if (paddr == `CPR_ADDR_DATA) begin
      if (!idx_open) begin
        next_err = 1'b1; // [RULE1] [RULE6]
      end else if (config_select_index == `CPR_IDX_PAR) begin
        next_prdata = {24'h00_0000, par_v};
      end else if (config_select_index == `CPR_IDX_SER) begin
        next_prdata = {24'h00_0000, ser_v};
      end else if (config_select_index == `CPR_IDX_PIN) begin
        next_prdata = {24'h00_0000, pin_v};
      end
    end else if (paddr == `CPR_ADDR_EXT) begin
      if (cfg_state & unlocked) begin
        next_prdata = {30'h0000_0000, ext_setup};
      end else begin
        next_err = 1'b1; // [RULE6]
      end
    end else if (paddr == `CPR_ADDR_STATUS) begin
      next_prdata = {29'h0000_0000, ~unlocked, cfg_state, 1'b1};
    end else begin
      next_err = 1'b1;
    end
  end

  // ready rises in the cycle after the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_err;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // control outputs to the peripherals
  // -----------------------------------------------------------------
  reg [1:0] next_role;

  // shared pin 92 role decode
  always @* begin
    if (!pin_v[`CPR_PIN_QUAL]) begin
      next_role = `CPR_PIN92_SECOND_DRIVE_INPUT; // [RULE17]
    end else if (pin_v[`CPR_PIN_IRQ]) begin
      next_role = `CPR_PIN92_IRQ;
    end else begin
      next_role = `CPR_PIN92_QUAL;
    end
  end

  // registered controls; address decode not touched by power bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_powered                 <= 1'b1;
      par_mode_printer            <= 1'b1;
      par_mode                    <= `CPR_PMODE_PRN;
      uart1_powered               <= 1'b1;
      uart2_powered               <= 1'b1;
      fast_infrared_block_powered <= 1'b1;
      enhanced_floppy_two         <= 1'b0;
      floppy_if_mode              <= `CPR_FLOP_AT;
      drive_density_out           <= 1'b1;
      pin_game_port_select        <= 1'b0;
      pin92_role                  <= `CPR_PIN92_SECOND_DRIVE_INPUT;
      pin92_out                   <= 1'b0;
      cfg_locked                  <= 1'b0;
    end else begin
      par_powered                 <= par_v[`CPR_PAR_PWR]; // [RULE4] [RULE8] [RULE10]
      par_mode_printer            <= par_v[`CPR_PAR_PRN]; // [RULE5]
      par_mode                    <= par_v[`CPR_PAR_PRN] ? `CPR_PMODE_PRN
                                     : {1'b0, ext_setup}; // [RULE5] [RULE18]
      uart1_powered               <= ser_v[`CPR_SER_PRI]; // [RULE11]
      uart2_powered               <= ser_v[`CPR_SER_SEC]; // [RULE12]
      fast_infrared_block_powered <= ser_v[`CPR_SER_SEC]; // [RULE12]
      enhanced_floppy_two         <= pin_v[`CPR_PIN_FLOP2]; // [RULE13]
      floppy_if_mode              <= {pin_v[`CPR_PIN_ID], pin_v[`CPR_PIN_ENC]}; // [RULE15]
      drive_density_out           <= pin_v[`CPR_PIN_DEN] | drive_density_prog; // [RULE14]
      pin_game_port_select        <= pin_v[`CPR_PIN_GAME]; // [RULE16]
      pin92_role                  <= next_role; // [RULE17]
      pin92_out                   <= (next_role == `CPR_PIN92_IRQ) & irq_b_req;
      cfg_locked                  <= ~unlocked; // [RULE7]
    end
  end

  // game port hits outside the game role decode into game_unused, which drives nothing
  reg game_unused;
  always @* begin
    game_unused = game_port_hit & ~pin_v[`CPR_PIN_GAME];
  end

endmodule

// File: sim/cpr_host.sv
/* apb host model that issues config register accesses.
   assumes pclk from the bench and a slave that answers with pready.
   peripheral base addresses stay untouched: disabling their decode by a
   base below 100h is left to software outside this bank */
`timescale 1ns/1ps
module cpr_host (
  // apb
  input  wire        pclk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer held until pready, entered just after a rising edge
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] rd, output err);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no cycle count assumed: only the bench watchdog ends a hung wait
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
endmodule

// File: sim/cpr_regs_sva.sv
/* assertions on the apb port and control outputs of the register bank.
   assumes a bind onto cpr_regs; sees its ports only. */
`include "cpr_consts.vh"
`timescale 1ns/1ps
module cpr_regs_chk (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // controls
  input wire        par_mode_printer,
  input wire [2:0]  par_mode,
  input wire        uart2_powered,
  input wire        fast_infrared_block_powered,
  input wire        drive_density_prog,
  input wire        drive_density_out,
  input wire [1:0]  pin92_role,
  input wire        pin92_out,
  input wire        cfg_locked
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       acc = psel && penable && pready;
  wire       dat = acc && paddr == `CPR_ADDR_DATA;
  reg  [7:0] idx;
  reg        st;
  // shadow of index and config state from accepted writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 8'h00;
      st <= 1'b0;
    end else if (acc && pwrite && !pslverr && paddr == `CPR_ADDR_INDEX) begin
      idx <= pwdata[7:0];
    end else if (acc && pwrite && !pslverr && paddr == `CPR_ADDR_STATE) begin
      st <= pwdata[0];
    end
  end
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_OUT_OF_STATE: assert property (dat && !st |-> pslverr)
    else $error("data port open outside config state");
  AST_LOCKED_ERR: assert property (dat && cfg_locked |-> pslverr)
    else $error("data port open while locked");
  AST_LOCK_STICKY: assert property (cfg_locked |=> cfg_locked)
    else $error("lock released without reset");
  AST_LOCK_SETS: assert property (dat && pwrite && !pslverr && idx == `CPR_IDX_PAR
    && !pwdata[7] |-> ##[1:2] cfg_locked) else $error("lock clear had no effect");
  AST_RSVD_PAR: assert property (dat && !pwrite && !pslverr && idx == `CPR_IDX_PAR
    |-> (prdata & 32'hFFFFFF73) == 32'h10) else $error("parallel reserved bits wrong");
  AST_RSVD_SER: assert property (dat && !pwrite && !pslverr && idx == `CPR_IDX_SER
    |-> (prdata & 32'hFFFFFF77) == 32'h0) else $error("serial reserved bits wrong");
  AST_PRINTER: assert property (par_mode_printer |-> par_mode == `CPR_PMODE_PRN)
    else $error("printer mode with extended mode code");
  AST_FIR: assert property (uart2_powered == fast_infrared_block_powered)
    else $error("infrared power differs from second serial port");
  AST_DENSITY: assert property ($past(drive_density_prog) |-> drive_density_out)
    else $error("density output low while programmed high");
  AST_PIN92: assert property (pin92_role != `CPR_PIN92_IRQ |-> !pin92_out)
    else $error("shared pin driven outside interrupt role");
  COV_LOCK: cover property ($rose(cfg_locked));
  COV_ERR: cover property (acc && pslverr);
  COV_IRQ: cover property (pin92_role == `CPR_PIN92_IRQ && pin92_out);
endmodule
bind cpr_regs cpr_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .par_mode_printer(par_mode_printer),
  .par_mode(par_mode), .uart2_powered(uart2_powered),
  .fast_infrared_block_powered(fast_infrared_block_powered),
  .drive_density_prog(drive_density_prog), .drive_density_out(drive_density_out),
  .pin92_role(pin92_role), .pin92_out(pin92_out), .cfg_locked(cfg_locked));

// File: sim/tb_config_power_pinmux_regs.sv
/* self-checking bench for the config power and pin function registers.
   assumes cpr_host as apb master and the checker bound onto cpr_regs. */
`include "cpr_consts.vh"
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_config_power_pinmux_regs;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         drive_density_prog = 1'b0;
  reg         game_port_hit = 1'b0;
  reg         irq_b_req = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr;
  wire [7:0]  paddr;
  wire [31:0] pwdata, prdata;
  wire        par_powered, par_mode_printer, uart1_powered, uart2_powered, fir_pw;
  wire [2:0]  par_mode;
  wire        enhanced_floppy_two, drive_density_out, pin_game_port_select;
  wire [1:0]  floppy_if_mode, pin92_role;
  wire        pin92_out, cfg_locked;
  integer     err_count = 0;
  integer     num_checks = 0;
  reg  [31:0] rd;
  reg         er;
  reg  [7:0]  v;
  reg  [1:0]  r;
  integer     k;
  always #2.5 pclk = ~pclk;
  cpr_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cpr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .par_powered(par_powered), .par_mode_printer(par_mode_printer),
    .par_mode(par_mode), .uart1_powered(uart1_powered), .uart2_powered(uart2_powered),
    .fast_infrared_block_powered(fir_pw), .enhanced_floppy_two(enhanced_floppy_two),
    .floppy_if_mode(floppy_if_mode), .drive_density_prog(drive_density_prog),
    .drive_density_out(drive_density_out), .pin_game_port_select(pin_game_port_select),
    .game_port_hit(game_port_hit), .pin92_role(pin92_role), .pin92_out(pin92_out),
    .irq_b_req(irq_b_req), .cfg_locked(cfg_locked));
  task acc(input w, input [7:0] a, input [31:0] d);
    u_host.xfer(w, a, d, rd, er);
  endtask
  // index select, then the data port
  task cw(input [7:0] i, input [7:0] d);
    begin
      acc(1'b1, `CPR_ADDR_INDEX, {24'h0, i});
      acc(1'b1, `CPR_ADDR_DATA, {24'h0, d});
    end
  endtask
  task cr(input [7:0] i);
    begin
      acc(1'b1, `CPR_ADDR_INDEX, {24'h0, i});
      acc(1'b0, `CPR_ADDR_DATA, 32'h0);
    end
  endtask
  task close_out;
    begin
      if (err_count == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task t_defaults;
    begin
      `CHK("par_powered", 1'b1, par_powered)
      `CHK("printer", 1'b1, par_mode_printer)
      `CHK("uart1", 1'b1, uart1_powered)
      `CHK("infrared", 1'b1, fir_pw)
      acc(1'b1, `CPR_ADDR_STATE, 32'h1);
      cr(`CPR_IDX_PAR);
      `CHK("par reset", 32'h9C, rd)
      cr(`CPR_IDX_SER);
      `CHK("ser reset", 32'h88, rd)
      cr(`CPR_IDX_PIN);
      `CHK("pin reset", 32'h70, rd)
    end
  endtask
  task t_state;
    begin
      acc(1'b1, `CPR_ADDR_STATE, 32'h0);
      acc(1'b0, `CPR_ADDR_DATA, 32'h0);
      `CHK("closed err", 1'b1, er)
      `CHK("closed rd", 32'h0, rd)
      acc(1'b1, `CPR_ADDR_STATE, 32'h1);
      acc(1'b0, 8'h14, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      cw(8'h30, 8'h00);
      `CHK("index 30 err", 1'b1, er)
      cr(8'h05);
      `CHK("index 05 rd", 32'h0, rd)
    end
  endtask
  task t_par_ser;
    begin
      cw(`CPR_IDX_PAR, 8'hF3);
      cr(`CPR_IDX_PAR);
      `CHK("par rsvd", 32'h90, rd)
      `CHK("par_powered", 1'b0, par_powered)
      for (k = 0; k < 4; k = k + 1) begin
        acc(1'b1, `CPR_ADDR_EXT, k);
        @(posedge pclk);
        `CHK("par_mode", k[2:0], par_mode)
      end
      cw(`CPR_IDX_PAR, 8'h9C);
      cw(`CPR_IDX_SER, 8'h77);
      cr(`CPR_IDX_SER);
      `CHK("ser rsvd", 32'h0, rd)
      `CHK("uart1", 1'b0, uart1_powered)
      `CHK("uart2", 1'b0, uart2_powered)
      `CHK("par_mode", 3'h4, par_mode)
    end
  endtask
  // sweep pin function values, drive_density_prog and irq_b_req
  task t_pin;
    for (k = 0; k < 8; k = k + 1) begin
      v = k * 8'h25;
      r = v[7] ? (v[2] ? 2'h2 : 2'h1) : 2'h0;
      drive_density_prog <= k[0];
      irq_b_req <= ~k[0];
      cw(`CPR_IDX_PIN, v);
      cr(`CPR_IDX_PIN);
      `CHK("pin rd", {24'h0, v & 8'hF7}, rd)
      `CHK("floppy", v[6:5], floppy_if_mode)
      `CHK("enhanced", v[1], enhanced_floppy_two)
      `CHK("game", v[0], pin_game_port_select)
      `CHK("role", r, pin92_role)
      `CHK("pin92", r == 2'h2 && !k[0], pin92_out)
      `CHK("density", v[4] | k[0], drive_density_out)
    end
  endtask
  task t_lock;
    begin
      cw(`CPR_IDX_PAR, 8'h1C);
      @(posedge pclk);
      `CHK("locked", 1'b1, cfg_locked)
      cr(`CPR_IDX_PAR);
      `CHK("locked err", 1'b1, er)
      acc(1'b1, `CPR_ADDR_EXT, 32'h1);
      `CHK("ext err", 1'b1, er)
      cw(`CPR_IDX_PAR, 8'h9C);
      acc(1'b0, `CPR_ADDR_STATUS, 32'h0);
      `CHK("status", 32'h7, rd)
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK("unlocked", 1'b0, cfg_locked)
      acc(1'b1, `CPR_ADDR_STATE, 32'h1);
      cr(`CPR_IDX_PAR);
      `CHK("par after reset", 32'h9C, rd)
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults;
    t_state;
    t_par_ser;
    t_pin;
    t_lock;
    close_out;
  end
  // watchdog well beyond the expected run
  initial begin
    #40000;
    err_count++;
    close_out;
  end
endmodule
